// ### alu_pkg.sv
package alu_pkg;

  // ==========================================================================
  // register map (byte addresses on the apb bus)
  localparam int unsigned APB_AW        = 8;
  localparam logic [7:0]  REG_CMD       = 8'h00;
  localparam logic [7:0]  REG_CTRL_WORD = 8'h04;
  localparam logic [7:0]  REG_FLAGS     = 8'h08;
  localparam logic [7:0]  REG_DST_LO    = 8'h0C;
  localparam logic [7:0]  REG_DST_HI    = 8'h10;
  localparam logic [7:0]  REG_SRC       = 8'h14;
  localparam logic [7:0]  REG_LOWER     = 8'h18;
  localparam logic [7:0]  REG_UPPER     = 8'h1C;
  localparam logic [7:0]  REG_SCALE     = 8'h20;
  localparam logic [7:0]  REG_STATUS    = 8'h24;

  // ==========================================================================
  // command word fields
  localparam int unsigned CMD_OP_LSB    = 0;
  localparam int unsigned CMD_OP_W      = 5;
  localparam int unsigned CMD_SIZE_LSB  = 8;
  localparam int unsigned CMD_SIZE_W    = 2;
  localparam int unsigned CMD_K_LSB     = 12;
  localparam int unsigned CMD_K_W       = 4;
  localparam int unsigned CMD_DST_MEM   = 16;
  localparam int unsigned CMD_SRC_MEM   = 17;
  localparam int unsigned CMD_SRC_IMM   = 18;

  // ==========================================================================
  // flag_control_word, flags and status layouts
  localparam int unsigned CTRL_OVF_EN   = 0;
  localparam int unsigned FL_C          = 0;
  localparam int unsigned FL_Z          = 1;
  localparam int unsigned FL_S          = 2;
  localparam int unsigned FL_V          = 3;
  localparam int unsigned FL_P          = 4;
  localparam int unsigned FL_D          = 5;
  localparam int unsigned FL_H          = 6;
  localparam int unsigned FLAGS_W       = 7;
  localparam int unsigned ST_OVF        = 0;
  localparam int unsigned ST_BOUNDS     = 1;
  localparam int unsigned ST_INDEX      = 2;
  localparam int unsigned ST_ILLEGAL    = 3;
  localparam int unsigned ST_W          = 4;
  localparam int unsigned ST_LOCK       = 4;
  localparam logic [FLAGS_W-1:0] FLAGS_RST = 7'h00;
  localparam logic [ST_W-1:0]    STAT_RST  = 4'h0;

  // ==========================================================================
  // operand widths and decimal adjust constants
  localparam int unsigned BYTE_BITS     = 8;
  localparam int unsigned WORD_BITS     = 16;
  localparam int unsigned LONG_BITS     = 32;
  localparam logic [7:0]  BCD_HI_ADJ    = 8'h60;
  localparam logic [7:0]  BCD_LO_ADJ    = 8'h06;
  localparam logic [7:0]  BCD_MAX       = 8'h99;
  localparam logic [3:0]  BCD_DIGIT_MAX = 4'h9;

  typedef enum logic [1:0] {
    SZ_BYTE = 2'b00,
    SZ_WORD = 2'b01,
    SZ_LONG = 2'b10,
    SZ_RSVD = 2'b11
  } op_size_t;

  typedef enum logic [4:0] {
    OP_ADD       = 5'b00000,
    OP_ADC       = 5'b00001,
    OP_SUB       = 5'b00010,
    OP_SBC       = 5'b00011,
    OP_CP        = 5'b00100,
    OP_INC       = 5'b00101,
    OP_DEC       = 5'b00110,
    OP_LINC      = 5'b00111,
    OP_LDEC      = 5'b01000,
    OP_NEG       = 5'b01001,
    OP_TEST_ZERO = 5'b01010,
    OP_MULT      = 5'b01011,
    OP_MULTU     = 5'b01100,
    OP_DIV       = 5'b01101,
    OP_DIVU      = 5'b01110,
    OP_SIGN_EXT  = 5'b01111,
    OP_DEC_ADJ   = 5'b10000,
    OP_BOUNDS    = 5'b10001,
    OP_INDEX     = 5'b10010,
    OP_AND       = 5'b10011,
    OP_OR        = 5'b10100,
    OP_XOR       = 5'b10101,
    OP_COM       = 5'b10110,
    OP_TEST      = 5'b10111
  } alu_op_t;

endpackage : alu_pkg

// ### integer_arith_logic_unit.sv
// The implementer's own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none

module integer_arith_logic_unit
  import alu_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              rst,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [APB_AW-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  output logic                   mem_lock,
  output logic                   overflow_trap,
  output logic                   bounds_trap,
  output logic                   index_trap
);

  // ==========================================================================
  // helpers
  function automatic logic [63:0] zext64(input logic [63:0] v, input int unsigned n);
    logic [63:0] m;
    m = (64'h1 << n) - 64'h1;
    if (n >= 64) begin
      m = {64{1'b1}};
    end
    return v & m;
  endfunction : zext64

  function automatic logic [63:0] sext64(input logic [63:0] v, input int unsigned n);
    logic signed [63:0] t;
    t = $signed(v << (64 - n));
    return $unsigned(t >>> (64 - n));
  endfunction : sext64

  // ==========================================================================
  // state
  logic [31:0]         dst_lo_q;
  logic [31:0]         dst_hi_q;
  logic [31:0]         src_q;
  logic [31:0]         lower_q;
  logic [31:0]         upper_q;
  logic [31:0]         scale_q;
  logic                ovf_trap_en_q;
  logic [FLAGS_W-1:0]  flags_q;
  logic [ST_W-1:0]     status_q;
  logic [31:0]         prdata_q;
  logic                lock_q;
  logic                ovf_pulse_q;
  logic                bnd_pulse_q;
  logic                idx_pulse_q;

  // ==========================================================================
  // apb decode
  logic        wr_acc;
  logic        rd_setup;
  logic        mapped;
  logic        exec;
  logic [31:0] rd_mux;

  assign wr_acc  = psel && penable && pwrite;
  assign rd_setup = psel && !penable && !pwrite;
  assign exec    = wr_acc && (paddr == REG_CMD);
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;

  always_comb begin : read_decode
    mapped = 1'b1;
    rd_mux = 32'h0;
    if (paddr == REG_CMD) begin
      rd_mux = 32'h0;
    end else if (paddr == REG_CTRL_WORD) begin
      rd_mux[CTRL_OVF_EN] = ovf_trap_en_q;
    end else if (paddr == REG_FLAGS) begin
      rd_mux[FLAGS_W-1:0] = flags_q;
    end else if (paddr == REG_DST_LO) begin
      rd_mux = dst_lo_q;
    end else if (paddr == REG_DST_HI) begin
      rd_mux = dst_hi_q;
    end else if (paddr == REG_SRC) begin
      rd_mux = src_q;
    end else if (paddr == REG_LOWER) begin
      rd_mux = lower_q;
    end else if (paddr == REG_UPPER) begin
      rd_mux = upper_q;
    end else if (paddr == REG_SCALE) begin
      rd_mux = scale_q;
    end else if (paddr == REG_STATUS) begin
      rd_mux[ST_W-1:0] = status_q;
      rd_mux[ST_LOCK]  = lock_q;
    end else begin
      mapped = 1'b0;
    end
  end

  // ==========================================================================
  // execution datapath
  alu_op_t            op;
  op_size_t           sz;
  logic               dst_mem;
  logic               src_mem;
  logic               src_imm;
  logic               illegal;
  int unsigned        n;
  logic [63:0]        msk;
  logic [63:0]        a;
  logic [63:0]        b;
  logic [63:0]        kval;
  logic [63:0]        lhs;
  logic [63:0]        rhs;
  logic [63:0]        ar;
  logic [4:0]         nib;
  logic               is_sub;
  logic               cin;
  logic               arv;
  logic [63:0]        t1;
  logic [63:0]        t2;
  logic [63:0]        t3;
  logic [63:0]        t4;
  logic               sgn;
  logic               out_rng;
  logic [7:0]         bx;
  logic [31:0]        dst_lo_d;
  logic [31:0]        dst_hi_d;
  logic [FLAGS_W-1:0] flags_d;
  logic               wr_lo;
  logic               wr_hi;
  logic               ovf_ev;
  logic               bnd_ev;
  logic               idx_ev;
  logic               lock_req;

  always_comb begin : execute
    op      = alu_op_t'(pwdata[CMD_OP_LSB +: CMD_OP_W]);
    sz      = op_size_t'(pwdata[CMD_SIZE_LSB +: CMD_SIZE_W]);
    dst_mem = pwdata[CMD_DST_MEM];
    src_mem = pwdata[CMD_SRC_MEM];
    src_imm = pwdata[CMD_SRC_IMM];
    n = (sz == SZ_BYTE) ? BYTE_BITS : (sz == SZ_WORD) ? WORD_BITS : LONG_BITS;
    msk  = zext64({64{1'b1}}, n);
    a    = {32'h0, dst_lo_q} & msk;
    b    = {32'h0, src_q} & msk;
    kval = 64'(pwdata[CMD_K_LSB +: CMD_K_W]) + 64'h1;
    // illegal command checks: reserved size or opcode, operand placement, operand size
    illegal = (sz == SZ_RSVD) || (pwdata[CMD_OP_LSB +: CMD_OP_W] > OP_TEST);
    if (dst_mem && (op inside {OP_ADD, OP_ADC, OP_SUB, OP_SBC, OP_MULT, OP_MULTU, OP_DIV,
                               OP_DIVU, OP_DEC_ADJ, OP_SIGN_EXT, OP_INDEX, OP_AND, OP_OR,
                               OP_XOR})) begin
      illegal = 1'b1;
    end
    if ((src_mem || src_imm) && (op inside {OP_ADC, OP_SBC, OP_BOUNDS, OP_INDEX})) begin
      illegal = 1'b1;
    end
    if (dst_mem && !src_imm && op == OP_CP) begin
      illegal = 1'b1;
    end
    if (sz == SZ_BYTE && (op inside {OP_MULT, OP_MULTU, OP_DIV, OP_DIVU, OP_INDEX})) begin
      illegal = 1'b1;
    end
    if (sz != SZ_BYTE && op == OP_DEC_ADJ) begin
      illegal = 1'b1;
    end
    // shared adder
    is_sub = op inside {OP_SUB, OP_SBC, OP_CP, OP_DEC, OP_LDEC, OP_NEG, OP_TEST_ZERO};
    cin    = (op == OP_ADC || op == OP_SBC) ? flags_q[FL_C] : 1'b0;
    lhs    = (op == OP_NEG) ? 64'h0 : a;
    if (op inside {OP_INC, OP_DEC, OP_LINC, OP_LDEC}) begin
      rhs = kval;
    end else if (op == OP_NEG) begin
      rhs = a;
    end else if (op == OP_TEST_ZERO) begin
      rhs = 64'h0;
    end else begin
      rhs = b;
    end
    if (is_sub) begin
      ar  = lhs - rhs - 64'(cin);
      nib = {1'b0, lhs[3:0]} - {1'b0, rhs[3:0]} - 5'(cin);
      arv = (lhs[n-1] != rhs[n-1]) && (ar[n-1] != lhs[n-1]);
    end else begin
      ar  = lhs + rhs + 64'(cin);
      nib = {1'b0, lhs[3:0]} + {1'b0, rhs[3:0]} + 5'(cin);
      arv = (lhs[n-1] == rhs[n-1]) && (ar[n-1] != lhs[n-1]);
    end
    t1 = 64'h0;
    t2 = 64'h0;
    t3 = 64'h0;
    t4 = 64'h0;
    sgn = 1'b0;
    out_rng = 1'b0;
    bx = dst_lo_q[7:0];
    dst_lo_d = dst_lo_q;
    dst_hi_d = dst_hi_q;
    flags_d  = flags_q;
    wr_lo = 1'b0;
    wr_hi = 1'b0;
    ovf_ev = 1'b0;
    bnd_ev = 1'b0;
    idx_ev = 1'b0;
    lock_req = 1'b0;
    case (op)
      OP_ADD, OP_ADC, OP_SUB, OP_SBC, OP_CP, OP_INC, OP_DEC, OP_LINC, OP_LDEC, OP_NEG,
      OP_TEST_ZERO: begin
        flags_d[FL_C] = ar[n];
        flags_d[FL_Z] = (ar & msk) == 64'h0;
        flags_d[FL_S] = ar[n-1];
        flags_d[FL_V] = arv;
        if (sz == SZ_BYTE) begin
          flags_d[FL_D] = is_sub;
          flags_d[FL_H] = nib[4];
        end
        if (!(op inside {OP_CP, OP_TEST_ZERO})) begin
          wr_lo    = 1'b1;
          dst_lo_d = (dst_lo_q & ~msk[31:0]) | ar[31:0] & msk[31:0];
        end
        ovf_ev   = arv && !(op inside {OP_ADC, OP_SBC, OP_CP, OP_TEST_ZERO});
        lock_req = (op inside {OP_LINC, OP_LDEC}) && dst_mem;
      end
      OP_MULT, OP_MULTU: begin
        sgn = (op == OP_MULT);
        t1  = sgn ? sext64(a, n) : a;
        t2  = sgn ? sext64(b, n) : b;
        t3  = zext64(t1 * t2, 2 * n);
        flags_d[FL_V] = sgn ? (sext64(t3, n) != sext64(t3, 2 * n)) : ((t3 & ~msk) != 64'h0);
        flags_d[FL_C] = flags_d[FL_V];
        flags_d[FL_Z] = t3 == 64'h0;
        flags_d[FL_S] = t3[2*n-1];
        wr_lo    = 1'b1;
        dst_lo_d = t3[31:0];
        wr_hi    = (sz == SZ_LONG);
        dst_hi_d = t3[63:32];
      end
      OP_DIV, OP_DIVU: begin
        sgn = (op == OP_DIV);
        if (sz == SZ_LONG) begin
          t1 = {dst_hi_q, dst_lo_q};
        end else begin
          t1 = sgn ? sext64({32'h0, dst_lo_q}, LONG_BITS) : {32'h0, dst_lo_q};
        end
        t2 = sgn ? sext64(b, n) : b;
        if (b == 64'h0) begin
          t2 = 64'h1;
        end
        t3 = sgn ? $unsigned($signed(t1) / $signed(t2)) : t1 / t2;
        t4 = sgn ? $unsigned($signed(t1) % $signed(t2)) : t1 % t2;
        flags_d[FL_V] = (b == 64'h0) || (sgn ? (sext64(t3, n) != t3) : ((t3 & ~msk) != 64'h0));
        flags_d[FL_C] = b == 64'h0;
        flags_d[FL_Z] = (t3 & msk) == 64'h0;
        flags_d[FL_S] = t3[n-1];
        ovf_ev = flags_d[FL_V];
        // quotient low half, remainder high half; nothing stored on overflow
        if (!flags_d[FL_V]) begin
          wr_lo    = 1'b1;
          wr_hi    = (sz == SZ_LONG);
          dst_lo_d = (sz == SZ_LONG) ? t3[31:0] : {t4[15:0], t3[15:0]};
          dst_hi_d = t4[31:0];
        end
      end
      OP_SIGN_EXT: begin
        t1 = sext64(a, n);
        if (sz == SZ_BYTE) begin
          wr_lo    = 1'b1;
          dst_lo_d = {dst_lo_q[31:16], t1[15:0]};
        end else if (sz == SZ_WORD) begin
          wr_lo    = 1'b1;
          dst_lo_d = t1[31:0];
        end else begin
          wr_hi    = 1'b1;
          dst_hi_d = t1[63:32];
        end
      end
      OP_DEC_ADJ: begin
        if (!flags_q[FL_D]) begin
          t1[7:0] = ((flags_q[FL_C] || bx > BCD_MAX) ? BCD_HI_ADJ : 8'h00) |
                    ((flags_q[FL_H] || bx[3:0] > BCD_DIGIT_MAX) ? BCD_LO_ADJ : 8'h00);
          t2[7:0] = bx + t1[7:0];
          flags_d[FL_C] = flags_q[FL_C] || bx > BCD_MAX;
        end else begin
          t1[7:0] = (flags_q[FL_C] ? BCD_HI_ADJ : 8'h00) | (flags_q[FL_H] ? BCD_LO_ADJ : 8'h00);
          t2[7:0] = bx - t1[7:0];
        end
        flags_d[FL_Z] = t2[7:0] == 8'h00;
        flags_d[FL_S] = t2[7];
        wr_lo    = 1'b1;
        dst_lo_d = {dst_lo_q[31:8], t2[7:0]};
      end
      OP_BOUNDS, OP_INDEX: begin
        t1 = sext64(b, n);
        t2 = sext64({32'h0, lower_q}, n);
        t3 = sext64({32'h0, upper_q}, n);
        out_rng = ($signed(t1) < $signed(t2)) || ($signed(t1) > $signed(t3));
        bnd_ev  = out_rng && (op == OP_BOUNDS);
        idx_ev  = out_rng && (op == OP_INDEX);
        t4 = ((t1 - t2) + sext64(a, n)) * sext64({32'h0, scale_q}, n);
        if (op == OP_INDEX && !out_rng) begin
          wr_lo    = 1'b1;
          dst_lo_d = (dst_lo_q & ~msk[31:0]) | t4[31:0] & msk[31:0];
        end
      end
      OP_AND, OP_OR, OP_XOR, OP_COM, OP_TEST: begin
        if (op == OP_AND) begin
          t1 = a & b;
        end else if (op == OP_OR) begin
          t1 = a | b;
        end else if (op == OP_XOR) begin
          t1 = a ^ b;
        end else if (op == OP_COM) begin
          t1 = ~a & msk;
        end else begin
          t1 = a | 64'h0;
        end
        flags_d[FL_Z] = t1 == 64'h0;
        flags_d[FL_S] = t1[n-1];
        if (sz == SZ_BYTE) begin
          flags_d[FL_P] = ~^t1[7:0];
        end
        if (op != OP_TEST) begin
          wr_lo    = 1'b1;
          dst_lo_d = (dst_lo_q & ~msk[31:0]) | t1[31:0];
        end
      end
      default: begin
        wr_lo = 1'b0;
      end
    endcase
  end

  logic go;
  assign go = exec && !illegal;

  // ==========================================================================
  // operand registers: software loads, execution writes back
  always_ff @(posedge core_clk) begin
    if (rst) begin
      dst_lo_q <= 32'h0;
      dst_hi_q <= 32'h0;
    end else if (go) begin
      if (wr_lo) begin
        dst_lo_q <= dst_lo_d;
      end
      if (wr_hi) begin
        dst_hi_q <= dst_hi_d;
      end
    end else if (wr_acc && paddr == REG_DST_LO) begin
      dst_lo_q <= pwdata;
    end else if (wr_acc && paddr == REG_DST_HI) begin
      dst_hi_q <= pwdata;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      src_q   <= 32'h0;
      lower_q <= 32'h0;
      upper_q <= 32'h0;
      scale_q <= 32'h0;
    end else if (wr_acc && paddr == REG_SRC) begin
      src_q <= pwdata;
    end else if (wr_acc && paddr == REG_LOWER) begin
      lower_q <= pwdata;
    end else if (wr_acc && paddr == REG_UPPER) begin
      upper_q <= pwdata;
    end else if (wr_acc && paddr == REG_SCALE) begin
      scale_q <= pwdata;
    end
  end

  // ==========================================================================
  // flags and control word
  always_ff @(posedge core_clk) begin
    if (rst) begin
      flags_q <= FLAGS_RST;
    end else if (go) begin
      flags_q <= flags_d;
    end else if (wr_acc && paddr == REG_FLAGS) begin
      flags_q <= pwdata[FLAGS_W-1:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      ovf_trap_en_q <= 1'b0;
    end else if (wr_acc && paddr == REG_CTRL_WORD) begin
      ovf_trap_en_q <= pwdata[CTRL_OVF_EN];
    end
  end

  // ==========================================================================
  // traps: sticky status (set beats write-one-clear) and one-cycle pulses
  logic [ST_W-1:0] st_set;
  logic [ST_W-1:0] st_clr;

  always_comb begin
    st_set = '0;
    st_set[ST_OVF]     = go && ovf_ev && ovf_trap_en_q;
    st_set[ST_BOUNDS]  = go && bnd_ev;
    st_set[ST_INDEX]   = go && idx_ev;
    st_set[ST_ILLEGAL] = exec && illegal;
    st_clr = (wr_acc && paddr == REG_STATUS) ? pwdata[ST_W-1:0] : '0;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      status_q <= STAT_RST;
    end else begin
      status_q <= (status_q & ~st_clr) | st_set;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      ovf_pulse_q <= 1'b0;
      bnd_pulse_q <= 1'b0;
      idx_pulse_q <= 1'b0;
    end else begin
      ovf_pulse_q <= st_set[ST_OVF];
      bnd_pulse_q <= st_set[ST_BOUNDS];
      idx_pulse_q <= st_set[ST_INDEX];
    end
  end

  // ==========================================================================
  // bus lock: held from the locked operation until the result is fetched or the next command is written,
  // so no other master can touch the memory word between read and write-back
  always_ff @(posedge core_clk) begin
    if (rst) begin
      lock_q <= 1'b0;
    end else if (go && lock_req) begin
      lock_q <= 1'b1;
    end else if (psel && penable && !pwrite && paddr == REG_DST_LO) begin
      lock_q <= 1'b0;
    end else if (exec) begin
      lock_q <= 1'b0;
    end
  end

  // ==========================================================================
  // read data captured in the setup phase
  always_ff @(posedge core_clk) begin
    if (rst) begin
      prdata_q <= 32'h0;
    end else if (rd_setup) begin
      prdata_q <= rd_mux;
    end
  end

  assign prdata        = prdata_q;
  assign mem_lock      = lock_q;
  assign overflow_trap = ovf_pulse_q;
  assign bounds_trap   = bnd_pulse_q;
  assign index_trap    = idx_pulse_q;

endmodule : integer_arith_logic_unit

`default_nettype wire

// ### integer_arith_logic_unit_asserts.sv
`timescale 1ns/100ps
`default_nettype none
// ========================
// port checks
module alu_checker
  import alu_pkg::*;
(
  input wire logic              core_clk,
  input wire logic              rst,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [APB_AW-1:0] paddr,
  input wire logic              pslverr,
  input wire logic              mem_lock,
  input wire logic              overflow_trap,
  input wire logic              bounds_trap,
  input wire logic              index_trap
);
  logic cmd_acc;
  assign cmd_acc = psel && penable && pwrite && paddr == REG_CMD;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  a_ovf_after_cmd: assert property (overflow_trap |-> $past(cmd_acc))
    else $error("overflow trap without command");
  a_ovf_one_pulse: assert property (overflow_trap |=> !overflow_trap)
    else $error("overflow trap longer than one cycle");
  a_bnd_after_cmd: assert property (bounds_trap |-> $past(cmd_acc))
    else $error("bounds trap without command");
  a_idx_after_cmd: assert property (index_trap |-> $past(cmd_acc))
    else $error("index trap without command");
  a_traps_apart: assert property ($onehot0({overflow_trap, bounds_trap, index_trap}))
    else $error("two traps at once");
  a_lock_rise_cmd: assert property ($rose(mem_lock) |-> $past(cmd_acc))
    else $error("lock rose without command");
  a_lock_held_idle: assert property (mem_lock && !(psel && penable) |=> mem_lock)
    else $error("lock dropped while bus idle");
  a_err_access: assert property (pslverr |-> psel && penable && paddr != REG_CMD)
    else $error("error outside access");
  c_ovf: cover property (overflow_trap);
  c_lock: cover property ($rose(mem_lock));
  c_err: cover property (pslverr);
endmodule : alu_checker
bind integer_arith_logic_unit alu_checker u_chk (.core_clk, .rst, .psel, .penable, .pwrite,
  .paddr, .pslverr, .mem_lock, .overflow_trap, .bounds_trap, .index_trap);
`default_nettype wire

// ### test_integer_arith_logic_unit.sv
`timescale 1ns/100ps
`default_nettype none
module test_integer_arith_logic_unit
  import alu_pkg::*;
;
  logic        core_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, err, sz, z, s;
  logic [7:0]  paddr = 8'h00, trap_cnt_q;
  logic [31:0] pwdata = 32'h0, prdata, rd, a, b, e, seed = 32'h17E9E;
  logic [2:0]  tr;
  logic [1:0]  o;
  logic        pready, pslverr, mem_lock, overflow_trap, bounds_trap, index_trap;
  int          mismatches = 0, compares = 0, i;
  integer_arith_logic_unit u_dut (.core_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .mem_lock, .overflow_trap, .bounds_trap, .index_trap);
  trap_monitor u_mon (.core_clk, .rst, .traps({overflow_trap, bounds_trap, index_trap}),
    .trap_cnt_q);
  initial forever #4 core_clk = ~core_clk;
  // ========================
  // helpers
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task automatic chk(input logic [31:0] sv, input logic [31:0] xv);
    compares++;
    if (sv !== xv) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, sv, xv);
    end
  endtask : chk
  task automatic tally_and_finish();
    if (mismatches == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : tally_and_finish
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    int n;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    for (n = 0; n < 16; n++) begin
      @(posedge core_clk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 16) begin
      mismatches++;
      tally_and_finish();
    end
  endtask : apb
  // trap pulses land one cycle after the command edge
  task automatic run(input logic [4:0] op, input logic [1:0] sz2, input logic [3:0] k,
                     input logic dm);
    apb(1'b1, REG_CMD, {15'h0, dm, k, 2'h0, sz2, 3'h0, op});
    @(posedge core_clk);
    tr = {overflow_trap, bounds_trap, index_trap};
  endtask : run
  // loads both operands, runs one register command, fetches the destination into rd
  task automatic do_op(input logic [4:0] op, input logic [1:0] sz2, input logic [31:0] d,
                       input logic [31:0] s);
    apb(1'b1, REG_DST_LO, d);
    apb(1'b1, REG_SRC, s);
    run(op, sz2, 4'h0, 1'b0);
    apb(1'b0, REG_DST_LO, 32'h0);
  endtask : do_op
  // ========================
  // scenarios
  initial begin
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    apb(1'b0, 8'h28, 32'h0);
    chk(32'(err), 32'h1);
    apb(1'b1, REG_CTRL_WORD, 32'h1);
    apb(1'b1, REG_DST_LO, 32'h7F);
    apb(1'b1, REG_SRC, 32'h1);
    run(OP_ADD, SZ_BYTE, 4'h0, 1'b0);
    chk(32'(tr), 32'h4);
    apb(1'b0, REG_DST_LO, 32'h0);
    chk(rd, 32'h80);
    apb(1'b0, REG_FLAGS, 32'h0);
    chk(rd, 32'h4C);
    apb(1'b1, REG_DST_LO, 32'hFFFFFFF0);
    run(OP_INC, SZ_LONG, 4'hF, 1'b0);
    apb(1'b0, REG_FLAGS, 32'h0);
    chk(rd & 32'h3, 32'h3);
    apb(1'b1, REG_DST_LO, 32'h5);
    apb(1'b1, REG_SRC, 32'h5);
    run(OP_CP, SZ_LONG, 4'h0, 1'b0);
    apb(1'b0, REG_DST_LO, 32'h0);
    chk(rd, 32'h5);
    apb(1'b0, REG_FLAGS, 32'h0);
    chk(rd & 32'h2, 32'h2);
    apb(1'b1, REG_DST_LO, 32'h0);
    run(OP_LINC, SZ_LONG, 4'h0, 1'b1);
    chk(32'(mem_lock), 32'h1);
    apb(1'b0, REG_DST_LO, 32'h0);
    chk(rd, 32'h1);
    @(posedge core_clk);
    chk(32'(mem_lock), 32'h0);
    apb(1'b1, REG_SRC, 32'h10);
    apb(1'b1, REG_UPPER, 32'hF);
    for (i = 0; i < 2; i++) begin
      run(5'h11 + 5'(i), 2'(2 - i), 4'h0, 1'b0);
      chk(32'(tr), 32'h2 >> i);
    end
    for (i = 0; i < 10; i++) begin
      a = rnd();
      b = (i == 0) ? a : rnd();
      o = (i == 0) ? 2'h2 : 2'(rnd() % 3);
      sz = 1'(rnd() & 32'h1);
      apb(1'b1, REG_DST_LO, a);
      apb(1'b1, REG_SRC, b);
      run(5'(OP_AND) + 5'(o), {1'b0, sz}, 4'h0, 1'b0);
      e = (o == 0) ? a & b : (o == 1) ? a | b : a ^ b;
      e = sz ? {a[31:16], e[15:0]} : {a[31:8], e[7:0]};
      apb(1'b0, REG_DST_LO, 32'h0);
      chk(rd, e);
      z = sz ? e[15:0] == 16'h0 : e[7:0] == 8'h0;
      s = sz ? e[15] : e[7];
      apb(1'b0, REG_FLAGS, 32'h0);
      chk(rd & (sz ? 32'h6 : 32'h16), {27'h0, ~^e[7:0] & !sz, 1'b0, s, z, 1'b0});
    end
    do_op(OP_MULT, SZ_LONG, 32'hFFFFFFFF, 32'h2);
    chk(rd, 32'hFFFFFFFE);
    apb(1'b0, REG_DST_HI, 32'h0);
    chk(rd, 32'hFFFFFFFF);
    apb(1'b1, REG_DST_HI, 32'h1);
    do_op(OP_DIVU, SZ_LONG, 32'h0, 32'h10);
    chk(rd, 32'h10000000);
    do_op(OP_DIV, SZ_WORD, 32'h7, 32'h0);
    chk(32'(tr), 32'h4);
    chk(rd, 32'h7);
    do_op(OP_NEG, SZ_LONG, 32'h5, 32'h0);
    chk(rd, 32'hFFFFFFFB);
    do_op(OP_TEST_ZERO, SZ_BYTE, 32'h80, 32'h0);
    chk(rd, 32'h80);
    apb(1'b0, REG_FLAGS, 32'h0);
    chk(rd & 32'hF, 32'h4);
    do_op(OP_ADD, SZ_BYTE, 32'h19, 32'h28);
    do_op(OP_DEC_ADJ, SZ_BYTE, 32'h41, 32'h0);
    chk(rd, 32'h47);
    do_op(OP_SIGN_EXT, SZ_BYTE, 32'h80, 32'h0);
    chk(rd, 32'hFF80);
    apb(1'b1, REG_LOWER, 32'h2);
    apb(1'b1, REG_SCALE, 32'h4);
    do_op(OP_INDEX, SZ_WORD, 32'h10, 32'h5);
    chk(rd, 32'h4C);
    chk(32'(tr), 32'h0);
    do_op(OP_COM, SZ_WORD, 32'h12345678, 32'h0);
    chk(rd, 32'h1234A987);
    do_op(OP_TEST, SZ_BYTE, 32'h100, 32'h0);
    chk(rd, 32'h100);
    apb(1'b0, REG_FLAGS, 32'h0);
    chk(rd & 32'h16, 32'h12);
    run(OP_ADC, SZ_BYTE, 4'h0, 1'b1);
    apb(1'b0, REG_STATUS, 32'h0);
    chk(rd & 32'h8, 32'h8);
    chk(32'(trap_cnt_q), 32'h4);
    tally_and_finish();
  end
endmodule : test_integer_arith_logic_unit
`default_nettype wire

// ### trap_monitor.sv
`timescale 1ns/100ps
`default_nettype none
// ========================
// exception side, counts every trap pulse
module trap_monitor (
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic [2:0] traps,
  output var  logic [7:0] trap_cnt_q
);
  // pulses are one cycle, so a plain sum never double counts
  always_ff @(posedge core_clk) begin
    if (rst) begin
      trap_cnt_q <= 8'h00;
    end else begin
      trap_cnt_q <= trap_cnt_q + 8'(traps[2]) + 8'(traps[1]) + 8'(traps[0]);
    end
  end
endmodule : trap_monitor
`default_nettype wire
